// file: rtl/pin_edge_detect.sv
// Synchroniser and edge detector for one external timer input.
// Assumes the pin is asynchronous to clk_i; outputs are in the clk_i domain.
`timescale 1ns/100ps
module pin_edge_detect
    import timer_input_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_b_i,
    input  wire logic       pin_i,
    input  wire logic [1:0] edge_sel_i,
    output logic            level_o,
    output logic            rise_o,
    output logic            fall_o,
    output logic            edge_o
);

    logic meta_q;
    logic sync_q;
    logic prev_q;

    // ****************************************************************
    // Two-stage synchroniser, then one history stage
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level_o = sync_q;
    assign rise_o  = sync_q & ~prev_q;
    assign fall_o  = ~sync_q & prev_q;
    assign edge_o  = (rise_o & edge_sel_i[0]) | (fall_o & edge_sel_i[1]);

endmodule : pin_edge_detect

// file: rtl/timer_input_pin_assignment.sv
// External input pin assignment of a 16-bit multifunction timer.
// Assumes a plain register port and pins driven by outside signal sources.
`timescale 1ns/100ps
module timer_input_pin_assignment
    import timer_input_pkg::*;
(
    input  wire logic                             clk_i,
    input  wire logic                             rst_b_i,
    input  wire logic                             timer_input_a_i,
    input  wire logic                             timer_input_b_i,
    input  wire logic [timer_input_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [timer_input_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                             wr_i,
    input  wire logic                             rd_i,
    output logic      [timer_input_pkg::DATA_W-1:0] rdata_o,
    output logic                                  count_tick_o,
    output logic                                  count_up_o,
    output logic                                  reg0_load_o,
    output logic                                  reg0_capture_o,
    output logic                                  reg1_capture_o
);

    import timer_input_pkg::*;

    // ****************************************************************
    // Software-visible state
    // ****************************************************************
    logic [3:0]        input_function_code_q;
    logic [1:0]        input_a_edge_select_q;
    logic [1:0]        input_b_edge_select_q;
    logic              reg0_capture_select_q;
    logic              reg1_capture_select_q;
    logic              bivalue_enable_q;
    logic              soft_count_direction_q;

    // Block state and registered outputs
    logic [1:0]        presc_q;
    logic              dir_q;
    logic              dir_d;
    logic              tick_q;
    logic              load0_q;
    logic              cap0_q;
    logic              cap1_q;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;

    // ****************************************************************
    // Pin conditioning
    // ****************************************************************
    logic a_lvl;
    logic a_rise;
    logic a_fall;
    logic a_edge;
    logic b_lvl_raw;
    logic b_rise_raw;
    logic b_fall_raw;
    logic b_edge_raw;

    pin_edge_detect u_pin_a (
        .clk_i      (clk_i),
        .rst_b_i    (rst_b_i),
        .pin_i      (timer_input_a_i),
        .edge_sel_i (input_a_edge_select_q),
        .level_o    (a_lvl),
        .rise_o     (a_rise),
        .fall_o     (a_fall),
        .edge_o     (a_edge)
    );

    pin_edge_detect u_pin_b (
        .clk_i      (clk_i),
        .rst_b_i    (rst_b_i),
        .pin_i      (timer_input_b_i),
        .edge_sel_i (input_b_edge_select_q),
        .level_o    (b_lvl_raw),
        .rise_o     (b_rise_raw),
        .fall_o     (b_fall_raw),
        .edge_o     (b_edge_raw)
    );

    // Bivalue mode cuts input B off from every function
    wire b_en   = ~bivalue_enable_q;
    wire b_lvl  = b_lvl_raw & b_en;
    wire b_rise = b_rise_raw & b_en;
    wire b_fall = b_fall_raw & b_en;
    wire b_edge = b_edge_raw & b_en;

    // ****************************************************************
    // Function decode
    // ****************************************************************
    func_code_t fn;
    assign fn = func_code_t'(input_function_code_q);

    wire a_trig = (fn == FN_TRIG_A) || (fn == FN_TRIG_AB)
               || (fn == FN_TRIG_A_CLK_B) || (fn == FN_TRIG_A_GATE_B);
    wire b_trig = (fn == FN_TRIG_B) || (fn == FN_GATE_A_TRIG_B)
               || (fn == FN_TRIG_AB) || (fn == FN_CLK_A_TRIG_B);
    wire a_gate = (fn == FN_GATE_A) || (fn == FN_GATE_A_TRIG_B)
               || (fn == FN_GATE_A_CLK_B);
    wire b_gate = (fn == FN_TRIG_A_GATE_B);
    wire b_clk  = (fn == FN_CLK_B) || (fn == FN_GATE_A_CLK_B)
               || (fn == FN_LEVEL_DIR_CLK_B) || (fn == FN_TRIG_A_CLK_B);
    wire a_clk  = (fn == FN_CLK_A_TRIG_B);
    wire ud_clk = (fn == FN_CLK_UP_DOWN);
    wire ad_clk = (fn == FN_AUTODISCR);
    wire int_clk = ~(b_clk | a_clk | ud_clk | ad_clk);

    // A high gate level stops counting; a disabled B never closes the gate
    wire gate_open  = ~(a_gate & a_lvl) & ~(b_gate & b_lvl);
    wire presc_wrap = (presc_q == PRESC_LAST);

    // ****************************************************************
    // Count steps
    // ****************************************************************
    wire int_tick   = int_clk & presc_wrap & gate_open;
    wire ext_tick_b = b_clk & b_edge & gate_open;
    wire ext_tick_a = a_clk & a_edge;
    // Both edges in one cycle give a single down step
    wire ud_dn      = ud_clk & b_edge;
    wire ud_up      = ud_clk & a_edge & ~b_edge;
    // Raw transitions: the phase relation matters, not the edge select
    wire ad_up      = ad_clk & b_rise & ~a_lvl;
    wire ad_dn      = ad_clk & b_fall & ~a_lvl;
    wire tick_d     = int_tick | ext_tick_a | ext_tick_b
                    | ud_up | ud_dn | ad_up | ad_dn;

    // ****************************************************************
    // Triggers
    // ****************************************************************
    wire trig_a  = a_trig & a_edge;
    wire load0_d = trig_a & ~reg0_capture_select_q;
    wire cap0_d  = trig_a & reg0_capture_select_q;
    wire cap1_d  = b_trig & b_edge;

    // ****************************************************************
    // Direction
    // ****************************************************************
    always_comb begin
        case (fn)
            FN_CLK_UP_DOWN: begin
                dir_d = ud_dn ? 1'b0 : (ud_up ? 1'b1 : dir_q);
            end
            FN_LEVEL_DIR_CLK_B, FN_LEVEL_DIR: begin
                dir_d = a_lvl;
            end
            FN_TRIG_DIR: begin
                dir_d = b_edge ? 1'b0 : (a_edge ? 1'b1 : dir_q);
            end
            FN_AUTODISCR: begin
                dir_d = ad_dn ? 1'b0 : (ad_up ? 1'b1 : dir_q);
            end
            default: begin
                dir_d = soft_count_direction_q;
            end
        endcase
    end

    // ****************************************************************
    // Register port decode
    // ****************************************************************
    wire wr_icr = wr_i && (addr_i == OFF_INPUT_CONTROL);
    wire wr_tmr = wr_i && (addr_i == OFF_TIMER_MODE);
    wire wr_tcr = wr_i && (addr_i == OFF_TIMER_CONTROL);

    wire [DATA_W-1:0] icr_rd = {input_b_edge_select_q, input_a_edge_select_q,
                                input_function_code_q};
    wire [DATA_W-1:0] tmr_rd = {5'h00, bivalue_enable_q, reg1_capture_select_q,
                                reg0_capture_select_q};
    wire [DATA_W-1:0] tcr_rd = {7'h00, soft_count_direction_q};
    wire [DATA_W-1:0] sts_rd = {4'h0, gate_open, b_lvl, a_lvl, dir_q};

    always_comb begin
        rdata_d = 8'h00;
        if (rd_i) begin
            case (addr_i)
                OFF_INPUT_CONTROL: rdata_d = icr_rd;
                OFF_TIMER_MODE:    rdata_d = tmr_rd;
                OFF_TIMER_CONTROL: rdata_d = tcr_rd;
                OFF_INPUT_STATUS:  rdata_d = sts_rd;
                default:           rdata_d = 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            input_function_code_q <= INPUT_CONTROL_RST[ICR_CODE_LSB +: 4];
            input_a_edge_select_q <= INPUT_CONTROL_RST[ICR_ASEL_LSB +: 2];
            input_b_edge_select_q <= INPUT_CONTROL_RST[ICR_BSEL_LSB +: 2];
        end else if (wr_icr) begin
            input_function_code_q <= wdata_i[ICR_CODE_LSB +: 4];
            input_a_edge_select_q <= wdata_i[ICR_ASEL_LSB +: 2];
            input_b_edge_select_q <= wdata_i[ICR_BSEL_LSB +: 2];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            reg0_capture_select_q <= TIMER_MODE_RST[TMR_RM0_BIT];
            reg1_capture_select_q <= TIMER_MODE_RST[TMR_RM1_BIT];
            bivalue_enable_q      <= TIMER_MODE_RST[TMR_BM_BIT];
        end else if (wr_tmr) begin
            reg0_capture_select_q <= wdata_i[TMR_RM0_BIT];
            reg1_capture_select_q <= wdata_i[TMR_RM1_BIT];
            bivalue_enable_q      <= wdata_i[TMR_BM_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            soft_count_direction_q <= TIMER_CONTROL_RST[TCR_UDC_BIT];
        end else if (wr_tcr) begin
            soft_count_direction_q <= wdata_i[TCR_UDC_BIT];
        end
    end

    // ****************************************************************
    // Prescaler phase and outputs
    // ****************************************************************
    // The prescaler phase runs free so internal steps keep a fixed cadence
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            presc_q <= 2'h0;
        end else begin
            presc_q <= presc_wrap ? 2'h0 : presc_q + 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            tick_q  <= 1'b0;
            dir_q   <= DIR_RST;
            load0_q <= 1'b0;
            cap0_q  <= 1'b0;
            cap1_q  <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            tick_q  <= tick_d;
            dir_q   <= dir_d;
            load0_q <= load0_d;
            cap0_q  <= cap0_d;
            cap1_q  <= cap1_d;
            rdata_q <= rdata_d;
        end
    end

    assign count_tick_o   = tick_q;
    assign count_up_o     = dir_q;
    assign reg0_load_o    = load0_q;
    assign reg0_capture_o = cap0_q;
    assign reg1_capture_o = cap1_q;
    assign rdata_o        = rdata_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    AST_IDLE_CODE: assert property (
        (fn == FN_NONE) |=> (count_up_o == $past(soft_count_direction_q))
            && !reg0_load_o && !reg0_capture_o && !reg1_capture_o)
        else $error("code 0000 let a pin act or ignored the software direction");

    AST_PRESC_RATE: assert property (
        presc_wrap |=> !presc_wrap ##1 !presc_wrap ##1 presc_wrap)
        else $error("prescaler phase not one third of the clock");

    AST_GATE_A: assert property (
        (a_gate && a_lvl) |=> !count_tick_o)
        else $error("counter stepped while gate A was high");

    AST_TRIG_B: assert property (
        (b_trig && b_edge_raw && !bivalue_enable_q) |=> reg1_capture_o)
        else $error("trigger on B did not capture into register 1");

    AST_BIVALUE_B_OFF: assert property (
        bivalue_enable_q |=> !reg1_capture_o)
        else $error("input B acted in bivalue mode");

    AST_TRIG_A_LOAD: assert property (
        (trig_a && !reg0_capture_select_q) |=> reg0_load_o && !reg0_capture_o)
        else $error("trigger on A with capture select clear did not load");

    AST_TRIG_A_CAP: assert property (
        (trig_a && reg0_capture_select_q) |=> reg0_capture_o && !reg0_load_o)
        else $error("trigger on A with capture select set did not capture");

    AST_UP_DOWN_B_WINS: assert property (
        (fn == FN_CLK_UP_DOWN && b_edge) |=> count_tick_o && !count_up_o)
        else $error("down clock on B did not give a down step");

    AST_TRIG_DIR: assert property (
        (fn == FN_TRIG_DIR && b_edge) |=> !count_up_o)
        else $error("edge on B did not select down counting");

    AST_LEVEL_DIR: assert property (
        (fn == FN_LEVEL_DIR) |=> (count_up_o == $past(a_lvl)))
        else $error("direction did not follow the level of A");

    AST_AUTODISCR_HOLD: assert property (
        (fn == FN_AUTODISCR && a_lvl) |=> !count_tick_o)
        else $error("autodiscrimination stepped while A was high");

    AST_GATE_B: assert property (
        (b_gate && b_lvl) |=> !count_tick_o)
        else $error("counter stepped while gate B was high");

    AST_CLK_A_STEP: assert property (
        (a_clk && a_edge) |=> count_tick_o)
        else $error("clock edge on A did not give a step");

    AST_AUTODISCR_UP: assert property (
        (ad_clk && b_rise && !a_lvl) |=> count_tick_o && count_up_o)
        else $error("rising B with A low did not step up");

    COV_GATED_CLOCK_B: cover property (fn == FN_GATE_A_CLK_B && ext_tick_b);
    COV_AUTODISCR_DOWN: cover property (ad_dn ##1 count_tick_o && !count_up_o);
    COV_CAPTURE_BOTH: cover property (cap0_d && cap1_d);
    COV_BIVALUE_B_BLOCKED: cover property (bivalue_enable_q && b_edge_raw);

endmodule : timer_input_pin_assignment

// file: rtl/timer_input_pkg.sv
// Constants and types shared by the timer input pin assignment logic.
// Assumes one system clock domain and a plain strobe-based register port.
package timer_input_pkg;

    // ****************************************************************
    // Register port
    // ****************************************************************
    localparam int unsigned ADDR_W = 2;
    localparam int unsigned DATA_W = 8;

    localparam logic [ADDR_W-1:0] OFF_INPUT_CONTROL = 2'h0;
    localparam logic [ADDR_W-1:0] OFF_TIMER_MODE    = 2'h1;
    localparam logic [ADDR_W-1:0] OFF_TIMER_CONTROL = 2'h2;
    localparam logic [ADDR_W-1:0] OFF_INPUT_STATUS  = 2'h3;

    // Field positions
    localparam int unsigned ICR_CODE_LSB  = 0;
    localparam int unsigned ICR_ASEL_LSB  = 4;
    localparam int unsigned ICR_BSEL_LSB  = 6;
    localparam int unsigned TMR_RM0_BIT   = 0;
    localparam int unsigned TMR_RM1_BIT   = 1;
    localparam int unsigned TMR_BM_BIT    = 2;
    localparam int unsigned TCR_UDC_BIT   = 0;

    // Values after reset
    localparam logic [DATA_W-1:0] INPUT_CONTROL_RST = 8'h00;
    localparam logic [DATA_W-1:0] TIMER_MODE_RST    = 8'h00;
    localparam logic [DATA_W-1:0] TIMER_CONTROL_RST = 8'h01;
    localparam logic              DIR_RST           = 1'b1;

    // Prescaler runs at one third of the system clock
    localparam int unsigned       PRESC_DIV  = 3;
    localparam logic [1:0]        PRESC_LAST = 2'(PRESC_DIV - 1);

    // Edge select encoding
    localparam logic [1:0] EDGE_NONE    = 2'h0;
    localparam logic [1:0] EDGE_RISING  = 2'h1;
    localparam logic [1:0] EDGE_FALLING = 2'h2;
    localparam logic [1:0] EDGE_BOTH    = 2'h3;

    typedef enum logic [3:0] {
        FN_NONE            = 4'h0,
        FN_TRIG_B          = 4'h1,
        FN_GATE_A          = 4'h2,
        FN_GATE_A_TRIG_B   = 4'h3,
        FN_CLK_B           = 4'h4,
        FN_TRIG_A          = 4'h5,
        FN_GATE_A_CLK_B    = 4'h6,
        FN_TRIG_AB         = 4'h7,
        FN_CLK_UP_DOWN     = 4'h8,
        FN_LEVEL_DIR_CLK_B = 4'h9,
        FN_TRIG_DIR        = 4'hA,
        FN_LEVEL_DIR       = 4'hB,
        FN_AUTODISCR       = 4'hC,
        FN_TRIG_A_CLK_B    = 4'hD,
        FN_CLK_A_TRIG_B    = 4'hE,
        FN_TRIG_A_GATE_B   = 4'hF
    } func_code_t;

endpackage : timer_input_pkg

// file: testbench/pin_source.sv
// Model of the outside sources that drive timer inputs A and B.
// Assumes the bench calls its tasks from just after a rising clk_i edge.
`timescale 1ns/100ps
module pin_source (
    input  wire logic clk_i,
    output logic      pin_a_o,
    output logic      pin_b_o
);
    // Long enough for a gate pulse of two prescaler periods
    localparam int unsigned HOLD = 7;

    initial begin
        pin_a_o = 1'b0;
        pin_b_o = 1'b0;
    end

    task automatic set_pin(input logic sel_b, input logic level);
        @(posedge clk_i);
        if (sel_b) begin
            pin_b_o <= level;
        end else begin
            pin_a_o <= level;
        end
        repeat (HOLD) @(posedge clk_i);
    endtask : set_pin

    task automatic pulse(input logic sel_b);
        set_pin(sel_b, 1'b1);
        set_pin(sel_b, 1'b0);
    endtask : pulse
endmodule : pin_source

// file: testbench/timer_input_pin_assignment_tb.sv
// Self-checking bench for the timer input pin assignment block.
// Assumes the pin source model drives both timer inputs.
`timescale 1ns/100ps
module timer_input_pin_assignment_tb;
    import timer_input_pkg::*;

    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    localparam logic [3:0] GATE_CODES [3] = '{4'h2, 4'h3, 4'hF};
    localparam logic [3:0] CLK_CODES [6] = '{4'h4, 4'h6, 4'h6, 4'h9, 4'hD, 4'hE};
    localparam logic       CLK_AHI [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    logic              clk_i   = 1'b0;
    logic              rst_b_i = 1'b0;
    logic [ADDR_W-1:0] addr_i  = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic              wr_i    = 1'b0;
    logic              rd_i    = 1'b0;
    logic [DATA_W-1:0] rdata_o;
    logic              tick;
    logic              up;
    logic              ld0;
    logic              cp0;
    logic              cp1;
    logic              pin_a;
    logic              pin_b;
    logic [7:0]        lfsr_q  = 8'h26;
    logic [DATA_W-1:0] d;
    int                fails    = 0;
    int                compares = 0;
    int                n [4]    = '{default: 0};
    int                s [4];

    always #50 clk_i = ~clk_i;

    // Running event counts; scenarios only look at differences
    always @(posedge clk_i) begin
        n[0] <= n[0] + int'(tick === 1'b1);
        n[1] <= n[1] + int'(ld0 === 1'b1);
        n[2] <= n[2] + int'(cp0 === 1'b1);
        n[3] <= n[3] + int'(cp1 === 1'b1);
    end

    pin_source src (.clk_i(clk_i), .pin_a_o(pin_a), .pin_b_o(pin_b));
    timer_input_pin_assignment uut (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .timer_input_a_i(pin_a),
        .timer_input_b_i(pin_b),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .count_tick_o(tick),
        .count_up_o(up),
        .reg0_load_o(ld0),
        .reg0_capture_o(cp0),
        .reg1_capture_o(cp1)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr_next
    function automatic logic [31:0] n_edges(input logic [1:0] sel);
        return 32'(sel[0]) + 32'(sel[1]);
    endfunction : n_edges
    function automatic logic a_trig(input logic [3:0] c);
        return c inside {4'h5, 4'h7, 4'hD, 4'hF};
    endfunction : a_trig
    function automatic logic b_trig(input logic [3:0] c);
        return c inside {4'h1, 4'h3, 4'h7, 4'hE};
    endfunction : b_trig
    function automatic logic [31:0] dn(input int i);
        return 32'(n[i] - s[i]);
    endfunction : dn

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic finish_test();
        if (fails == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= v;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
        @(posedge clk_i);
        v = rdata_o;
    endtask : rd
    // The settle time flushes ticks already in the output pipeline
    task automatic cfg(input logic [7:0] icr, input logic [7:0] tmr, input logic [7:0] timer_control_reg);
        wr(OFF_TIMER_MODE, tmr);
        wr(OFF_TIMER_CONTROL, timer_control_reg);
        wr(OFF_INPUT_CONTROL, icr);
        repeat (4) @(posedge clk_i);
    endtask : cfg
    task automatic win(input int cycles);
        s = n;
        repeat (cycles) @(posedge clk_i);
    endtask : win
    // All-ones for et means internal ticks run and are not counted
    task automatic step(input logic sel_b, input logic [31:0] et, input logic eu);
        s = n;
        src.pulse(sel_b);
        repeat (4) @(posedge clk_i);
        if (et !== '1) check("steps", dn(0), et);
        check("direction", 32'(up), 32'(eu));
        check("no_trigger", dn(1) + dn(2) + dn(3), 32'd0);
    endtask : step

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        logic [3:0] c;
        logic [2:0] m;
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        check("count_up_reset", 32'(up), 32'(DIR_RST));
        rd(OFF_INPUT_CONTROL, d);
        check("input_control_reg", 32'(d), 32'(INPUT_CONTROL_RST));
        rd(OFF_TIMER_MODE, d);
        check("timer_mode_reg", 32'(d), 32'(TIMER_MODE_RST));
        rd(OFF_TIMER_CONTROL, d);
        check("timer_control_reg", 32'(d), 32'(TIMER_CONTROL_RST));
        @(negedge clk_i);
        check("rdata_idle", 32'(rdata_o), 32'h0);
        cfg(8'hF0, 8'h00, 8'h00);
        src.set_pin(1'b0, 1'b1);
        src.set_pin(1'b1, 1'b1);
        win(30);
        check("ticks_code0", dn(0), 32'd10);
        check("trig_code0", dn(1) + dn(2) + dn(3), 32'd0);
        check("soft_dir", 32'(up), 32'd0);
        src.set_pin(1'b0, 1'b0);
        src.set_pin(1'b1, 1'b0);
        foreach (GATE_CODES[i]) begin
            cfg({4'h0, GATE_CODES[i]}, 8'h00, 8'h01);
            src.set_pin(GATE_CODES[i] == 4'hF, 1'b1);
            win(30);
            check("gate_shut", dn(0), 32'd0);
            src.set_pin(GATE_CODES[i] == 4'hF, 1'b0);
            win(30);
            check("gate_open", dn(0), 32'd10);
        end
        for (int i = 0; i < 6; i++) begin
            cfg(8'h50 | 8'(CLK_CODES[i]), 8'h00, 8'h01);
            src.set_pin(1'b0, CLK_AHI[i]);
            s = n;
            repeat (3) src.pulse(CLK_CODES[i] != 4'hE);
            repeat (4) @(posedge clk_i);
            check("ext_ticks", dn(0),
                  (CLK_CODES[i] == 4'h6 && CLK_AHI[i]) ? 32'd0 : 32'd3);
            check("ext_dir", 32'(up), 32'(CLK_CODES[i] != 4'h9 || CLK_AHI[i]));
            src.set_pin(1'b0, 1'b0);
        end
        cfg(8'h58, 8'h00, 8'h00);
        step(1'b0, 32'd1, 1'b1);
        cfg(8'h58, 8'h00, 8'h01);
        step(1'b1, 32'd1, 1'b0);
        cfg(8'h5A, 8'h00, 8'h00);
        step(1'b0, '1, 1'b1);
        cfg(8'h5A, 8'h00, 8'h01);
        step(1'b1, '1, 1'b0);
        cfg(8'h0C, 8'h00, 8'h01);
        step(1'b1, 32'd2, 1'b0);
        src.set_pin(1'b0, 1'b1);
        step(1'b1, 32'd0, 1'b0);
        cfg(8'h0B, 8'h00, 8'h00);
        check("level_up", 32'(up), 32'd1);
        // Status: gate open, B low, A high, counting up
        rd(OFF_INPUT_STATUS, d);
        check("input_status", 32'(d), 32'h0B);
        cfg(8'h0B, 8'h00, 8'h01);
        src.set_pin(1'b0, 1'b0);
        check("level_down", 32'(up), 32'd0);
        for (int i = 0; i < 32; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            c = 4'(i);
            m = lfsr_q[6:4];
            cfg({lfsr_q[3:0], c}, {5'h0, m}, 8'h01);
            rd(OFF_INPUT_CONTROL, d);
            check("icr_readback", 32'(d), 32'({lfsr_q[3:0], c}));
            rd(OFF_TIMER_MODE, d);
            check("tmr_readback", 32'(d), 32'({5'h0, m}));
            s = n;
            src.pulse(1'b0);
            src.pulse(1'b1);
            repeat (4) @(posedge clk_i);
            check("reg0_load", dn(1),
                  (a_trig(c) && !m[0]) ? n_edges(lfsr_q[1:0]) : 32'd0);
            check("reg0_capture", dn(2),
                  (a_trig(c) && m[0]) ? n_edges(lfsr_q[1:0]) : 32'd0);
            check("reg1_capture", dn(3),
                  (b_trig(c) && !m[2]) ? n_edges(lfsr_q[3:2]) : 32'd0);
        end
        // Reset in mid-run must restore every register and restart the prescaler
        rst_b_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        check("count_up_rerun", 32'(up), 32'(DIR_RST));
        rd(OFF_INPUT_CONTROL, d);
        check("input_control_rerun", 32'(d), 32'(INPUT_CONTROL_RST));
        rd(OFF_TIMER_MODE, d);
        check("timer_mode_rerun", 32'(d), 32'(TIMER_MODE_RST));
        win(30);
        check("ticks_rerun", dn(0), 32'd10);
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        finish_test();
    end
endmodule : timer_input_pin_assignment_tb
